// ==== hw/shcp_device.sv ====
// Device end: mode strap, serial command registers, config selection
`timescale 1ns/1ps
`include "shcp_map.svh"
module shcp_device
	import shcp_pkg::*;
#(
	parameter int NCHAN = `SHCP_NCHAN
) (
	input  wire logic                   clk_in,       // System clock
	input  wire logic                   rst_in,       // Sync reset, high
	shcp_if.dev                         link,         // Serial pins
	input  wire logic                   mode_strap_select_in, // 1 = host
	input  wire shcp_pins_type [NCHAN-1:0] pins_in,   // Config pins
	input  wire logic [NCHAN-1:0][`SHCP_FIELD_W-1:0] status_in, // Status
	output logic                        host_mode_out, // Mode in use
	output shcp_cfg_type [NCHAN-1:0]    cfg_out       // Active config
);

	// Pin synchronisers: cs_n, sclk, sdi, sdo line, register_reset_in_n, strap
	logic [5:0]                 ser_s1_ff;
	logic [5:0]                 ser_s2_ff;
	shcp_pins_type [NCHAN-1:0]  pins_s1_ff;
	shcp_pins_type [NCHAN-1:0]  pins_s2_ff;
	logic                       sclk_d_ff;
	logic                       cs_d_ff;

	// Serial engine state
	logic [3:0]                 cnt_ff;
	logic                       rw_ff;
	logic [5:0]                 addr_ff;
	logic [`SHCP_DATA_W-1:0]    wsh_ff;
	logic [`SHCP_DATA_W-1:0]    rsh_ff;
	logic                       sdo_ff;
	logic                       oe_ff;
	logic [`SHCP_FIELD_W-1:0]   cr_ff [NCHAN][`SHCP_REGS_PER_CH];
	shcp_cfg_type [NCHAN-1:0]   cfg_ff;
	logic                       mode_ff;

	wire cs_s   = ser_s2_ff[0];
	wire sclk_s = ser_s2_ff[1];
	wire sdi_s  = ser_s2_ff[2];
	wire sdo_s  = ser_s2_ff[3];
	wire register_reset_in_s = ser_s2_ff[4];
	wire host_s = ser_s2_ff[5];

	always_ff @(posedge clk_in) begin
		ser_s1_ff  <= {mode_strap_select_in, link.register_reset_in_n, link.sdo_line,
			link.serial_data_in, link.sclk, link.cs_n};
		ser_s2_ff  <= ser_s1_ff;
		pins_s1_ff <= pins_in;
		pins_s2_ff <= pins_s1_ff;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sclk_d_ff <= 1'b0;
			cs_d_ff   <= 1'b1;
			mode_ff   <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_s;
			cs_d_ff   <= cs_s;
			mode_ff   <= host_s;
		end
	end

	wire active  = mode_ff & host_s & ~cs_s;
	wire rise    = active & sclk_s & ~sclk_d_ff;
	wire fall    = active & ~sclk_s & sclk_d_ff;
	wire cs_rise = cs_s & ~cs_d_ff;

	wire [1:0] a_ch  = addr_ff[4:3];
	wire [2:0] a_reg = addr_ff[2:0];
	wire       a_ok  = ~addr_ff[5] && (32'(a_ch) < NCHAN);
	wire [`SHCP_FIELD_W-1:0] rd_field =
		!a_ok ? `SHCP_CR_RESET :
		(a_reg == 3'h0) ? status_in[a_ch] : cr_ff[a_ch][a_reg];
	wire [`SHCP_DATA_W-1:0] rd_val =
		{{(`SHCP_DATA_W-`SHCP_FIELD_W){1'b0}}, rd_field};

	wire hdr_done   = (cnt_ff == 4'(`SHCP_HDR_BITS));
	wire frame_done = (cnt_ff == 4'(`SHCP_FRAME_BITS));
	wire commit = cs_rise & mode_ff & frame_done & ~rw_ff & a_ok
		& (a_reg != 3'h0);

	always_ff @(posedge clk_in) begin
		if (rst_in || cs_s || !mode_ff) begin
			cnt_ff  <= 4'h0;
		end else if (rise && !frame_done) begin
			cnt_ff  <= cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rw_ff   <= 1'b0;
			addr_ff <= 6'h00;
			wsh_ff  <= 8'h00;
		end else if (rise && !frame_done) begin
			if (cnt_ff == 4'h0) begin
				rw_ff   <= sdi_s;
			end else if (cnt_ff < 4'(`SHCP_HDR_BITS)) begin
				addr_ff <= {sdi_s, addr_ff[5:1]};
			end else begin
				wsh_ff  <= {sdi_s, wsh_ff[`SHCP_DATA_W-1:1]};
			end
		end
	end

	// read data moves on falling edges
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rsh_ff <= 8'h00;
			sdo_ff <= 1'b0;
		end else if (fall && rw_ff && cnt_ff >= 4'(`SHCP_HDR_BITS)
				&& !frame_done) begin
			sdo_ff <= hdr_done ? rd_val[0] : rsh_ff[0];
			rsh_ff <= hdr_done ? (rd_val >> 1) : (rsh_ff >> 1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= mode_ff & host_s & ~cs_s;
		end
	end

	assign link.sdo_dev = sdo_ff;
	assign link.sdo_oe  = oe_ff;

	always_ff @(posedge clk_in) begin
		if (rst_in || (mode_ff && !register_reset_in_s)) begin
			for (int c = 0; c < NCHAN; c++) begin
				for (int r = 0; r < `SHCP_REGS_PER_CH; r++) begin
					cr_ff[c][r] <= `SHCP_CR_RESET;
				end
			end
		end else if (commit) begin
			cr_ff[a_ch][a_reg] <= wsh_ff[`SHCP_FIELD_W-1:0];
		end
	end

	// Per-channel selection between pin and register sources
	for (genvar c = 0; c < NCHAN; c++) begin : g_ch
		shcp_pins_type p;
		shcp_cfg_type  hw_cfg;
		shcp_cfg_type  hs_cfg;
		logic [`SHCP_FIELD_W-1:0] r1;
		logic [`SHCP_FIELD_W-1:0] r2;
		logic [`SHCP_FIELD_W-1:0] r3;
		logic [`SHCP_FIELD_W-1:0] r4;

		assign p  = pins_s2_ff[c];
		assign r1 = cr_ff[c][1];
		assign r2 = cr_ff[c][2];
		assign r3 = cr_ff[c][3];
		assign r4 = cr_ff[c][4];

		assign hw_cfg.tx_driver_off       = p.tx_driver_off;
		assign hw_cfg.tx_level_select     = p.tx_level_select;
		assign hw_cfg.tx_all_ones_send    = p.tx_all_ones_send;
		assign hw_cfg.rx_equalizer_enable = p.rx_equalizer_enable;
		assign hw_cfg.remote_loopback     = p.remote_loopback;
		assign hw_cfg.local_loopback      = p.local_loopback;
		assign hw_cfg.sonet_rate_select   = p.sonet_rate_select;
		assign hw_cfg.e_rate_select = (c == 0) ? sdo_s : p.e_rate_select;
		assign hw_cfg.receiver_power_off = (c == 0) ? sdi_s :
			(c == 1) ? sclk_s : p.receiver_power_off;
		assign hw_cfg.codec_bypass    = cs_s;
		assign hw_cfg.rx_clock_invert = register_reset_in_s;

		assign hs_cfg.tx_driver_off = p.tx_driver_off
			| r1[`SHCP_CR1_DRV_OFF];
		assign hs_cfg.tx_level_select     = r1[`SHCP_CR1_LEVEL];
		assign hs_cfg.tx_all_ones_send    = r1[`SHCP_CR1_ALL_ONES];
		assign hs_cfg.rx_equalizer_enable = r2[`SHCP_CR2_EQ_EN];
		assign hs_cfg.codec_bypass        = r2[`SHCP_CR2_BYPASS];
		assign hs_cfg.receiver_power_off  = r3[`SHCP_CR3_RX_OFF];
		assign hs_cfg.rx_clock_invert     = r3[`SHCP_CR3_RX_INV];
		assign hs_cfg.remote_loopback     = r4[`SHCP_CR4_REMOTE_LB];
		assign hs_cfg.local_loopback      = r4[`SHCP_CR4_LOCAL_LB];
		assign hs_cfg.e_rate_select       = r4[`SHCP_CR4_E_RATE];
		assign hs_cfg.sonet_rate_select   = r4[`SHCP_CR4_SONET];

		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				cfg_ff[c] <= '0;
			end else begin
				cfg_ff[c] <= mode_ff ? hs_cfg : hw_cfg;
			end
		end
	end

	assign cfg_out       = cfg_ff;
	assign host_mode_out = mode_ff;

endmodule

// ==== hw/shcp_host.sv ====
// Controller end: Avalon-MM registers driving the serial transfers
`timescale 1ns/1ps
`include "shcp_map.svh"
module shcp_host
	import shcp_pkg::*;
#(
	parameter int HALF_CYC = `SHCP_HALF_CYC,
	parameter int IDLE_CYC = `SHCP_IDLE_CYC
) (
	input  wire logic        clk_in,          // System clock
	input  wire logic        rst_in,          // Sync reset, high
	input  wire logic [1:0]  avs_address,     // Word index
	input  wire logic        avs_read,        // Read request
	input  wire logic        avs_write,       // Write request
	input  wire logic [31:0] avs_writedata,   // Write data
	output logic      [31:0] avs_readdata,    // Read data
	output logic             avs_waitrequest, // Stall
	shcp_if.host             link             // Serial pins
);

	shcp_hstate_type          state_ff;
	logic [7:0]               div_ff;
	logic [4:0]               half_ff;
	logic [`SHCP_FRAME_BITS-1:0] txsh_ff;
	logic [`SHCP_DATA_W-1:0]  rx_ff;
	logic [8:0]               cmd_ff;
	logic [`SHCP_DATA_W-1:0]  wdata_ff;
	logic                     register_reset_in_ff;
	logic                     cs_n_ff;
	logic                     sclk_ff;
	logic                     sdi_ff;
	logic                     sdo_s1_ff;
	logic                     sdo_s2_ff;
	logic                     ack_ff;
	logic [31:0]              rdata_ff;

	wire busy     = (state_ff != HS_IDLE);
	wire req      = avs_read | avs_write;
	wire cmd_hit  = avs_write && (avs_address == `SHCP_HR_CMD);
	// New command waits until the link is idle
	wire stall    = cmd_hit & busy;
	wire take     = req & ack_ff;
	wire start    = take & cmd_hit;
	// Gap keeps its own count; a half-period tick must not cut it short
	wire tick     = (state_ff != HS_GAP) && (32'(div_ff) == HALF_CYC - 1);
	wire gap_done = (32'(div_ff) == IDLE_CYC - 1);
	wire last_h   = (half_ff == 5'(2 * `SHCP_FRAME_BITS - 1));
	wire [31:0] rd_mux =
		(avs_address == `SHCP_HR_CMD)  ? {23'h00_0000, cmd_ff} :
		(avs_address == `SHCP_HR_DATA) ? {24'h00_0000, rx_ff} :
		(avs_address == `SHCP_HR_STATUS) ? {31'h0000_0000, busy} :
		{31'h0000_0000, register_reset_in_ff};
	// read bit, address with A5 zero, data
	wire [`SHCP_FRAME_BITS-1:0] frame = {
		(avs_writedata[`SHCP_CMD_RW_BIT] ? 8'h00 : wdata_ff),
		1'b0, avs_writedata[4:0], avs_writedata[`SHCP_CMD_RW_BIT]};

	assign avs_waitrequest = req & ~ack_ff;
	assign avs_readdata    = rdata_ff;
	assign link.cs_n       = cs_n_ff;
	assign link.sclk       = sclk_ff;
	assign link.serial_data_in        = sdi_ff;
	assign link.register_reset_in_n     = ~register_reset_in_ff;

	always_ff @(posedge clk_in) begin
		sdo_s1_ff <= link.sdo_line;
		sdo_s2_ff <= sdo_s1_ff;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ack_ff   <= 1'b0;
			rdata_ff <= `SHCP_HR_RESET;
			cmd_ff   <= 9'h000;
			wdata_ff <= 8'h00;
			register_reset_in_ff  <= 1'b0;
		end else begin
			ack_ff   <= req & ~ack_ff & ~stall;
			rdata_ff <= rd_mux;
			if (start) begin
				cmd_ff <= {avs_writedata[8], 2'h0, avs_writedata[5:0]};
			end
			if (take && avs_write && avs_address == `SHCP_HR_DATA) begin
				wdata_ff <= avs_writedata[7:0];
			end
			if (take && avs_write && avs_address == `SHCP_HR_CTRL) begin
				register_reset_in_ff <= avs_writedata[0];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_ff <= HS_IDLE;
			div_ff   <= 8'h00;
			half_ff  <= 5'h00;
			txsh_ff  <= '0;
			rx_ff    <= 8'h00;
			cs_n_ff  <= 1'b1;
			sclk_ff  <= 1'b0;
			sdi_ff   <= 1'b0;
		end else begin
			div_ff <= (busy && !tick && !(state_ff == HS_GAP && gap_done))
				? div_ff + 8'h01 : 8'h00;
			unique case (state_ff)
				HS_IDLE: begin
					// select falls half a period before first rise
					if (start) begin
						cs_n_ff  <= 1'b0;
						sdi_ff   <= frame[0];
						txsh_ff  <= frame >> 1;
						half_ff  <= 5'h00;
						state_ff <= HS_RUN;
					end
				end
				HS_RUN: begin
					if (tick) begin
						half_ff <= half_ff + 5'h01;
						sclk_ff <= ~half_ff[0];
						// sample device data on rising edges
						if (!half_ff[0] && half_ff[4:1] >= 4'(`SHCP_HDR_BITS)) begin
							rx_ff <= {sdo_s2_ff, rx_ff[7:1]};
						end
						if (half_ff[0]) begin
							sdi_ff  <= txsh_ff[0];
							txsh_ff <= txsh_ff >> 1;
						end
						if (last_h) begin
							state_ff <= HS_TAIL;
						end
					end
				end
				HS_TAIL: begin
					if (tick) begin
						cs_n_ff  <= 1'b1;
						state_ff <= HS_GAP;
					end
				end
				HS_GAP: begin
					if (gap_done) begin
						state_ff <= HS_IDLE;
					end
				end
			endcase
		end
	end

endmodule

// ==== hw/shcp_if.sv ====
// Five-wire serial configuration link between controller and device
`timescale 1ns/1ps
interface shcp_if;
	logic cs_n;
	logic sclk;
	logic serial_data_in;
	logic register_reset_in_n;
	logic sdo_dev;
	logic sdo_oe;
	wire  sdo_line;

	// Weak pull-down when the device does not drive the data out pin
	assign sdo_line = sdo_oe ? sdo_dev : 1'b0;

	modport dev (
		input  cs_n,
		input  sclk,
		input  serial_data_in,
		input  register_reset_in_n,
		input  sdo_line,
		output sdo_dev,
		output sdo_oe
	);

	modport host (
		output cs_n,
		output sclk,
		output serial_data_in,
		output register_reset_in_n,
		input  sdo_line
	);
endinterface

// ==== hw/shcp_map.svh ====
// Constants for the serial host configuration port and its controller
// Functional notes
// - Strap low: configuration taken from input pins
// - Strap high: configuration taken from command registers
// - Hardware mode: serial port reads and writes nothing
// - Hardware mode: serial pins carry alternate configuration
// - Hardware mode: all remaining configuration pins honoured
// - Host mode: serial writes select channel configuration
// - Host mode: per-channel option pins are ignored
// - Host mode: driver-off pins still switch transmitters
// - One port; address picks channel and register
// - Host sends read bit one, A5 zero
// - Host sends write bit zero; device stores
// - Chip select low around all rising clock edges
// - Serial input sampled on rising serial clock
// - Read data changes after each falling edge
// - Data out released after chip select rises
// - Eight registers per channel, consecutive blocks
// - Register zero is read-only status
// - All register fields reset to zero
`ifndef SHCP_MAP_SVH
`define SHCP_MAP_SVH

`define SHCP_NCHAN       3
`define SHCP_REGS_PER_CH 8
`define SHCP_FIELD_W     5
`define SHCP_DATA_W      8
`define SHCP_HDR_BITS    7
`define SHCP_FRAME_BITS  15

// Command register fields
`define SHCP_CR1_DRV_OFF  4
`define SHCP_CR1_ALL_ONES 3
`define SHCP_CR1_LEVEL    1
`define SHCP_CR2_BYPASS   3
`define SHCP_CR2_EQ_EN    0
`define SHCP_CR3_RX_OFF   2
`define SHCP_CR3_RX_INV   1
`define SHCP_CR4_SONET    3
`define SHCP_CR4_E_RATE   2
`define SHCP_CR4_LOCAL_LB 1
`define SHCP_CR4_REMOTE_LB 0
`define SHCP_CR_RESET     5'h00

// Controller register word indices and fields
`define SHCP_HR_CMD      2'h0
`define SHCP_HR_DATA     2'h1
`define SHCP_HR_STATUS   2'h2
`define SHCP_HR_CTRL     2'h3
`define SHCP_CMD_RW_BIT  8
`define SHCP_HR_RESET    32'h0000_0000

// Serial timing
`define SHCP_CLK_NS        5
`define SHCP_SCLK_HALF_NS  80
`define SHCP_CS_IDLE_NS    160
`define SHCP_HALF_CYC  ((`SHCP_SCLK_HALF_NS + `SHCP_CLK_NS - 1) / `SHCP_CLK_NS)
`define SHCP_IDLE_CYC  ((`SHCP_CS_IDLE_NS + `SHCP_CLK_NS - 1) / `SHCP_CLK_NS)

`endif

// ==== hw/shcp_pkg.sv ====
// Types shared by both ends of the serial configuration port
package shcp_pkg;

	typedef struct packed {
		logic tx_driver_off;
		logic tx_level_select;
		logic tx_all_ones_send;
		logic rx_equalizer_enable;
		logic remote_loopback;
		logic local_loopback;
		logic e_rate_select;
		logic sonet_rate_select;
		logic receiver_power_off;
	} shcp_pins_type;

	typedef struct packed {
		logic tx_driver_off;
		logic tx_level_select;
		logic tx_all_ones_send;
		logic rx_equalizer_enable;
		logic remote_loopback;
		logic local_loopback;
		logic e_rate_select;
		logic sonet_rate_select;
		logic receiver_power_off;
		logic codec_bypass;
		logic rx_clock_invert;
	} shcp_cfg_type;

	typedef enum logic [1:0] {
		HS_IDLE,
		HS_RUN,
		HS_TAIL,
		HS_GAP
	} shcp_hstate_type;

endpackage

// ==== tb/serial_host_config_port_test.sv ====
// Controller and device joined over the link, driven by register calls
`timescale 1ns/1ps
`include "shcp_map.svh"
module serial_host_config_port_test
	import shcp_pkg::*;
;
	localparam int NCH = `SHCP_NCHAN;
	logic                   clk_in;
	logic                   rst_in;
	logic                   host_rst;
	logic                   rst_any;
	logic [1:0]             avs_address;
	logic                   avs_read;
	logic                   avs_write;
	logic [31:0]            avs_writedata;
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	logic                   strap;
	shcp_pins_type [NCH-1:0] pins;
	logic [NCH-1:0][4:0]    status;
	logic                   host_mode;
	shcp_cfg_type [NCH-1:0] cfg;
	logic [31:0]            q;
	int                     err_total;
	int                     n_tests;
	logic [7:0]             wv [6] = '{8'h00, 8'h0a, 8'h09, 8'h04,
		8'h05, 8'hff};

	shcp_if link ();
	// Controller reset alone lets a frame be cut short
	assign rst_any = rst_in | host_rst;

	shcp_host #(.HALF_CYC(6), .IDLE_CYC(8)) i_shcp_host (
		.clk_in(clk_in), .rst_in(rst_any), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(link.host));
	shcp_device #(.NCHAN(NCH)) i_shcp_device (
		.clk_in(clk_in), .rst_in(rst_in), .link(link.dev),
		.mode_strap_select_in(strap), .pins_in(pins),
		.status_in(status), .host_mode_out(host_mode), .cfg_out(cfg));
	shcp_link_sva i_shcp_link_sva (.clk_in(clk_in), .rst_in(rst_any),
		.cs_n(link.cs_n), .sclk(link.sclk), .serial_data_in(link.serial_data_in),
		.sdo_dev(link.sdo_dev), .sdo_oe(link.sdo_oe),
		.host_mode_in(host_mode));

	always #2.5 clk_in = ~clk_in;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Request stands until waitrequest is seen low at a rising edge
	task automatic av(input logic rd, input logic [1:0] a,
			input logic [31:0] d);
		@(posedge clk_in);
		avs_address   <= a;
		avs_read      <= rd;
		avs_write     <= !rd;
		avs_writedata <= d;
		do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic idle();
		do av(1'b1, `SHCP_HR_STATUS, 32'h0000_0000); while (q[0] !== 1'b0);
	endtask

	task automatic ser(input logic rd, input logic [5:0] a,
			input logic [7:0] d);
		av(1'b0, `SHCP_HR_DATA, {24'h00_0000, d});
		av(1'b0, `SHCP_HR_CMD, {23'h00_0000, rd, 2'h0, a});
		idle();
		av(1'b1, `SHCP_HR_DATA, 32'h0000_0000);
	endtask

	// Idle link: select high, clock and data low, pull-down on data out
	function automatic shcp_cfg_type hw_exp(input int ch, input logic rg);
		shcp_cfg_type e;
		e = {pins[ch], 1'b1, rg};
		if (ch == 0)
			e.e_rate_select = 1'b0;
		if (ch < 2)
			e.receiver_power_off = 1'b0;
		return e;
	endfunction

	initial begin
		clk_in = 1'b0;
		rst_in = 1'b1;
		host_rst = 1'b0;
		strap = 1'b0;
		avs_address = 2'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		pins = {9'h1a5, 9'h0f3, 9'h16e};
		status = {5'h15, 5'h0a, 5'h13};
		err_total = 0;
		n_tests = 0;
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		chk(32'(host_mode), 32'h0000_0000);
		for (int c = 0; c < NCH; c++)
			chk(32'(cfg[c]), 32'(hw_exp(c, 1'b1)));
		av(1'b0, `SHCP_HR_CTRL, 32'h0000_0001);
		repeat (8) @(posedge clk_in);
		chk(32'(cfg[2]), 32'(hw_exp(2, 1'b0)));
		av(1'b0, `SHCP_HR_CTRL, 32'h0000_0000);
		av(1'b0, `SHCP_HR_DATA, 32'h0000_001f);
		av(1'b0, `SHCP_HR_CMD, 32'h0000_0001);
		repeat (20) @(posedge clk_in);
		chk(32'(cfg[0].codec_bypass), 32'h0000_0000);
		idle();
		strap <= 1'b1;
		repeat (10) @(posedge clk_in);
		chk(32'(host_mode), 32'h0000_0001);
		ser(1'b1, 6'h01, 8'h00);
		chk(q, 32'h0000_0000);
		pins <= {3{9'h0ff}};
		for (int r = 1; r < 6; r++)
			ser(1'b0, 6'(8 + r), wv[r]);
		for (int r = 1; r < 6; r++) begin
			ser(1'b1, 6'(8 + r), 8'h00);
			chk(q, {24'h00_0000, wv[r] & 8'h1f});
		end
		chk(32'(cfg[1]), 32'h0000_03d6);
		chk(32'(cfg[0]), 32'h0000_0000);
		pins <= {3{9'h1ff}};
		repeat (8) @(posedge clk_in);
		chk(32'(cfg[1]), 32'h0000_07d6);
		chk(32'(cfg[2]), 32'h0000_0400);
		ser(1'b0, 6'h10, 8'h1f);
		ser(1'b1, 6'h10, 8'h00);
		chk(q, 32'h0000_0015);
		ser(1'b1, 6'h08, 8'h00);
		chk(q, 32'h0000_000a);
		ser(1'b1, 6'h18, 8'h00);
		chk(q, 32'h0000_0000);
		ser(1'b1, 6'h2a, 8'h00);
		chk(q, 32'h0000_0009);
		av(1'b0, `SHCP_HR_DATA, 32'h0000_0003);
		av(1'b0, `SHCP_HR_CMD, 32'h0000_000d);
		repeat (60) @(posedge clk_in);
		host_rst <= 1'b1;
		repeat (3) @(posedge clk_in);
		host_rst <= 1'b0;
		repeat (40) @(posedge clk_in);
		ser(1'b1, 6'h0d, 8'h00);
		chk(q, 32'h0000_001f);
		av(1'b0, `SHCP_HR_CTRL, 32'h0000_0001);
		repeat (8) @(posedge clk_in);
		av(1'b0, `SHCP_HR_CTRL, 32'h0000_0000);
		ser(1'b1, 6'h09, 8'h00);
		chk(q, 32'h0000_0000);
		conclude();
	end

	// Whole sequence needs a few thousand cycles
	initial begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		conclude();
	end
endmodule

// ==== tb/shcp_link_sva.sv ====
// Protocol checker for the serial link between controller and device
`timescale 1ns/1ps
module shcp_link_sva (
	input wire logic clk_in,        // System clock
	input wire logic rst_in,        // Any reset, high
	input wire logic cs_n,          // Chip select
	input wire logic sclk,          // Serial clock
	input wire logic serial_data_in,           // Data to device
	input wire logic sdo_dev,       // Device data out
	input wire logic sdo_oe,        // Device drive enable
	input wire logic host_mode_in   // Mode in effect
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	logic [4:0] rise_cnt_ff;
	logic       sclk_q_ff;

	// Rising edges so far in the open frame
	always_ff @(posedge clk_in) begin
		sclk_q_ff <= sclk;
		if (rst_in || cs_n)
			rise_cnt_ff <= 5'h00;
		else if (sclk && !sclk_q_ff)
			rise_cnt_ff <= rise_cnt_ff + 5'h01;
	end

	sequence s_frame_end;
		$rose(cs_n);
	endsequence

	sequence s_released;
		##[1:8] !sdo_oe;
	endsequence

	a_sclk_in_frame: assert property (
		$rose(sclk) |-> !cs_n && !$past(cs_n))
		else $error("serial clock rose outside a frame");
	a_cs_end_low: assert property (
		s_frame_end |-> !sclk && !$past(sclk))
		else $error("frame closed with serial clock high");
	a_sdi_held: assert property (
		sclk |-> $stable(serial_data_in))
		else $error("serial input moved while clock high");
	a_addr_top_zero: assert property (
		$rose(sclk) && rise_cnt_ff == 5'h06 |-> !serial_data_in)
		else $error("top address bit sent as one");
	a_frame_len: assert property (
		s_frame_end |-> rise_cnt_ff == 5'h0f)
		else $error("frame without fifteen clock edges");
	a_sdo_steady: assert property (
		sclk && $past(sclk) && sdo_oe |-> $stable(sdo_dev))
		else $error("data out moved while clock high");
	a_sdo_release: assert property (
		s_frame_end |-> s_released)
		else $error("data out still driven after frame");
	a_hw_port_off: assert property (
		!host_mode_in |-> !sdo_oe)
		else $error("data out driven in pin mode");
	a_oe_in_frame: assert property (
		$fell(cs_n) && host_mode_in |-> ##[1:8] sdo_oe)
		else $error("data out not driven in host frame");
endmodule
